// ===== include/uclb_pkg.sv
/*
 * Shared constants for the LIN break control block: register addresses,
 * field positions, reset values and break timing figures.
 * Assumes a byte-wide memory-mapped register port with 16-bit addresses.
 */
package uclb_pkg;
    // Register addresses
    localparam logic [15:0] ADDR_BREAK_CTRL_0 = 16'hff58;
    localparam logic [15:0] ADDR_BREAK_CTRL_1 = 16'hff3f;
    localparam logic [15:0] ADDR_ROUTE_SEL = 16'hff4f;

    // Break control register fields
    localparam int CTRL_RX_FLAG_BIT = 7;
    localparam int CTRL_RX_TRIG_BIT = 6;
    localparam int CTRL_TX_TRIG_BIT = 5;
    localparam int CTRL_LEN_HI = 4;
    localparam int CTRL_LEN_LO = 2;
    localparam int CTRL_DIR_BIT = 1;
    localparam int CTRL_INV_BIT = 0;
    localparam int CTRL_CFG_W = 5;
    localparam logic [7:0] CTRL_RESET = 8'h16;

    // Input route register fields
    localparam int ROUTE_IRQ_SRC_BIT = 7;
    localparam int ROUTE_EXT1_BIT = 4;
    localparam int ROUTE_EXT0_BIT = 3;
    localparam int ROUTE_FIXED_BIT = 2;
    localparam int ROUTE_CAP_B_BIT = 1;
    localparam int ROUTE_CAP_A_BIT = 0;
    localparam logic [7:0] ROUTE_WRITE_MASK = 8'h9f;
    localparam logic [7:0] ROUTE_RESET = 8'h00;

    // Break timing, in bit periods
    localparam logic [4:0] BREAK_LEN_BASE = 5'h0d;
    localparam logic [2:0] BREAK_LEN_OFFSET = 3'h3;
    localparam logic [4:0] BREAK_RX_MIN_BITS = 5'h0b;
endpackage : uclb_pkg

// ===== rtl/uclb_chan.sv
/*
 * One channel's break engine: timed break transmission, break reception
 * with error recovery, and transmit line polarity.
 * Assumes a one-cycle bit-time tick from the baud generator, a receive
 * line already synchronised to i_sys_clk, and enables from the mode register.
 */
`timescale 1ns/100ps
module uclb_chan (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic i_power_en,
    input wire logic i_tx_en,
    input wire logic i_rx_en,
    input wire logic i_baud_tick,
    input wire logic i_tx_normal,
    input wire logic i_rx_line,
    input wire logic i_rx_start,
    input wire logic i_tx_start,
    input wire logic [2:0] i_length_code,
    input wire logic i_tx_invert,
    output logic o_tx_line,
    output logic o_rx_flag,
    output logic o_rx_done,
    output logic o_tx_done
);
    typedef enum logic [1:0] {TX_IDLE, TX_ALIGN, TX_LOW} uclb_tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_WAIT, RX_LOW} uclb_rx_state_t;

    uclb_tx_state_t tx_state;
    uclb_rx_state_t rx_state;
    logic [4:0] tx_cnt;
    logic [4:0] rx_cnt;
    logic [4:0] break_len;
    logic rx_level;
    logic next_tx_line;

    assign break_len = uclb_pkg::BREAK_LEN_BASE
        + {2'h0, 3'(i_length_code + uclb_pkg::BREAK_LEN_OFFSET)};
    // Input reads high while the channel is powered down
    assign rx_level = i_power_en ? i_rx_line : 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Break transmission: wait for a bit boundary, then hold space
    always_ff @(posedge i_sys_clk) begin
        o_tx_done <= 1'b0;
        if (!i_resetn || !i_power_en || !i_tx_en) begin
            tx_state <= TX_IDLE;
            tx_cnt <= 5'h00;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    if (i_tx_start) begin
                        tx_state <= TX_ALIGN;
                    end
                end
                TX_ALIGN: begin
                    if (i_baud_tick) begin
                        tx_state <= TX_LOW;
                        tx_cnt <= 5'h00;
                    end
                end
                TX_LOW: begin
                    if (i_baud_tick) begin
                        if (tx_cnt == 5'(break_len - 5'h01)) begin
                            tx_state <= TX_IDLE;
                            o_tx_done <= 1'b1;
                        end else begin
                            tx_cnt <= 5'(tx_cnt + 5'h01);
                        end
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    always_comb begin
        if (!i_power_en) begin
            next_tx_line = 1'b1;
        end else if (tx_state == TX_LOW) begin
            next_tx_line = i_tx_invert;
        end else begin
            next_tx_line = i_tx_normal ^ i_tx_invert;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_tx_line <= 1'b1;
        end else begin
            o_tx_line <= next_tx_line;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Break reception; powering down clears it at once, without the clock
    always_ff @(posedge i_sys_clk or negedge i_power_en) begin
        if (!i_power_en) begin
            rx_state <= RX_IDLE;
            o_rx_flag <= 1'b0;
            rx_cnt <= 5'h00;
            o_rx_done <= 1'b0;
        end else if (!i_resetn || !i_rx_en) begin
            rx_state <= RX_IDLE;
            o_rx_flag <= 1'b0;
            rx_cnt <= 5'h00;
            o_rx_done <= 1'b0;
        end else begin
            o_rx_done <= 1'b0;
            case (rx_state)
                RX_IDLE: begin
                    if (i_rx_start) begin
                        rx_state <= RX_WAIT;
                        o_rx_flag <= 1'b1;
                    end
                end
                RX_WAIT: begin
                    if (!rx_level) begin
                        rx_state <= RX_LOW;
                        rx_cnt <= 5'h00;
                    end
                end
                RX_LOW: begin
                    if (rx_level) begin
                        if (rx_cnt >= uclb_pkg::BREAK_RX_MIN_BITS) begin
                            rx_state <= RX_IDLE;
                            o_rx_flag <= 1'b0;
                            o_rx_done <= 1'b1;
                        end else begin
                            rx_state <= RX_WAIT;
                        end
                    end else if (i_baud_tick && rx_cnt != 5'h1f) begin
                        // Saturates so a stuck-low line is not miscounted
                        rx_cnt <= 5'(rx_cnt + 5'h01);
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_tx_polarity: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (i_power_en && tx_state != TX_LOW) |=> o_tx_line == $past(i_tx_normal ^ i_tx_invert))
        else $error("tx line polarity wrong");
    a_tx_break_level: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (i_power_en && tx_state == TX_LOW) |=> o_tx_line == $past(i_tx_invert))
        else $error("tx line not at space during break");
    a_tx_length_end: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn || !i_power_en)
        (i_tx_en && tx_state == TX_LOW && i_baud_tick && tx_cnt == 5'(break_len - 5'h01))
        |=> (tx_state == TX_IDLE && o_tx_done))
        else $error("break transmission did not end on length");
    a_rx_error_holds: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn || !i_power_en)
        (i_rx_en && rx_state == RX_LOW && rx_level && rx_cnt < uclb_pkg::BREAK_RX_MIN_BITS)
        |=> (rx_state == RX_WAIT && o_rx_flag))
        else $error("short break not handled as error");
    a_rx_done_clears: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn || !i_power_en)
        o_rx_done |-> (!o_rx_flag && rx_state == RX_IDLE))
        else $error("flag still set after break received");
    a_rx_start_held: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn || !i_power_en)
        (i_rx_en && rx_state == RX_IDLE && i_rx_start) |=> o_rx_flag [*2])
        else $error("break reception not held after trigger");
    c_tx_done: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) o_tx_done);
    c_rx_done: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) o_rx_done);
    c_rx_error: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
        rx_state == RX_LOW ##1 rx_state == RX_WAIT);
endmodule : uclb_chan

// ===== rtl/uclb_top.sv
/*
 * LIN break control for two serial channels: the two break control
 * registers, the input route register, pin synchronisers and routing.
 * Assumes a byte-wide memory-mapped register port on i_sys_clk, enables
 * and bit ticks from the mode register and baud generator on the same
 * clock, and asynchronous pins for the receive lines and routed inputs.
 */
`timescale 1ns/100ps
module uclb_top (
    input wire logic i_sys_clk,
    input wire logic i_resetn,
    input wire logic [15:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    input wire logic i_ch0_power_en,
    input wire logic i_ch0_tx_en,
    input wire logic i_ch0_rx_en,
    input wire logic i_ch0_baud_tick,
    input wire logic i_ch0_tx_normal,
    input wire logic i_ch0_serial_rx_line,
    output logic o_ch0_serial_tx_line,
    output logic o_ch0_first_bit_lsb,
    output logic o_ch0_break_rx_irq,
    output logic o_ch0_break_tx_irq,
    input wire logic i_ch1_power_en,
    input wire logic i_ch1_tx_en,
    input wire logic i_ch1_rx_en,
    input wire logic i_ch1_baud_tick,
    input wire logic i_ch1_tx_normal,
    input wire logic i_ch1_serial_rx_line,
    output logic o_ch1_serial_tx_line,
    output logic o_ch1_first_bit_lsb,
    output logic o_ch1_break_rx_irq,
    output logic o_ch1_break_tx_irq,
    input wire logic i_external_irq_0_pin,
    input wire logic i_external_irq_1_pin,
    input wire logic i_timer_capture_in_a_pin,
    input wire logic i_timer_capture_in_b_pin,
    input wire logic i_internal_timer_out,
    input wire logic i_watch_interval_irq,
    input wire logic i_muldiv_done_irq,
    output logic o_external_irq_0,
    output logic o_external_irq_1,
    output logic o_timer_capture_in_a,
    output logic o_timer_capture_in_b,
    output logic o_shared_irq
);
    // Synchroniser bit order: rx0, rx1, irq0 pin, irq1 pin, cap a pin, cap b pin
    localparam int SYNC_W = 6;

    logic [SYNC_W-1:0] pin_meta;
    logic [SYNC_W-1:0] pin_sync;
    logic [uclb_pkg::CTRL_CFG_W-1:0] cfg0;
    logic [uclb_pkg::CTRL_CFG_W-1:0] cfg1;
    logic [7:0] route;
    logic wr_ctrl0;
    logic wr_ctrl1;
    logic wr_route;
    logic rx_flag0;
    logic rx_flag1;
    logic rx0_eff;
    logic rx1_eff;
    logic [7:0] next_rdata;
    logic [7:0] next_route;

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for every pin input
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            pin_meta <= '1;
            pin_sync <= '1;
        end else begin
            pin_meta <= {i_timer_capture_in_b_pin, i_timer_capture_in_a_pin,
                         i_external_irq_1_pin, i_external_irq_0_pin,
                         i_ch1_serial_rx_line, i_ch0_serial_rx_line};
            pin_sync <= pin_meta;
        end
    end

    // An unpowered channel's receive input reads high everywhere it is routed
    assign rx0_eff = i_ch0_power_en ? pin_sync[0] : 1'b1;
    assign rx1_eff = i_ch1_power_en ? pin_sync[1] : 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Register decode
    assign wr_ctrl0 = i_wr && (i_addr == uclb_pkg::ADDR_BREAK_CTRL_0);
    assign wr_ctrl1 = i_wr && (i_addr == uclb_pkg::ADDR_BREAK_CTRL_1);
    assign wr_route = i_wr && (i_addr == uclb_pkg::ADDR_ROUTE_SEL);

    // Length, bit order and inversion are plain storage; the trigger bits
    // are not stored and so always read back as zero
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            cfg0 <= uclb_pkg::CTRL_RESET[uclb_pkg::CTRL_CFG_W-1:0];
        end else if (wr_ctrl0) begin
            cfg0 <= i_wdata[uclb_pkg::CTRL_CFG_W-1:0];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            cfg1 <= uclb_pkg::CTRL_RESET[uclb_pkg::CTRL_CFG_W-1:0];
        end else if (wr_ctrl1) begin
            cfg1 <= i_wdata[uclb_pkg::CTRL_CFG_W-1:0];
        end
    end

    // Bits 6 and 5 are hard zero; bit 2 keeps whatever software writes
    assign next_route = i_wdata & uclb_pkg::ROUTE_WRITE_MASK;

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            route <= uclb_pkg::ROUTE_RESET;
        end else if (wr_route) begin
            route <= next_route;
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        case (i_addr)
            uclb_pkg::ADDR_BREAK_CTRL_0: begin
                next_rdata = {rx_flag0, 2'h0, cfg0};
            end
            uclb_pkg::ADDR_BREAK_CTRL_1: begin
                next_rdata = {rx_flag1, 2'h0, cfg1};
            end
            uclb_pkg::ADDR_ROUTE_SEL: begin
                next_rdata = route;
            end
            default: next_rdata = 8'h00;
        endcase
    end

    // Read data is registered: valid the cycle after the read strobe
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_ch0_first_bit_lsb <= uclb_pkg::CTRL_RESET[uclb_pkg::CTRL_DIR_BIT];
            o_ch1_first_bit_lsb <= uclb_pkg::CTRL_RESET[uclb_pkg::CTRL_DIR_BIT];
        end else begin
            o_ch0_first_bit_lsb <= cfg0[uclb_pkg::CTRL_DIR_BIT];
            o_ch1_first_bit_lsb <= cfg1[uclb_pkg::CTRL_DIR_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Break engines; a trigger write during an active break is ignored
    // inside the engine, which keeps a refresh write harmless
    uclb_chan u_chan0 (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_power_en(i_ch0_power_en),
        .i_tx_en(i_ch0_tx_en),
        .i_rx_en(i_ch0_rx_en),
        .i_baud_tick(i_ch0_baud_tick),
        .i_tx_normal(i_ch0_tx_normal),
        .i_rx_line(pin_sync[0]),
        .i_rx_start(wr_ctrl0 && i_wdata[uclb_pkg::CTRL_RX_TRIG_BIT]),
        .i_tx_start(wr_ctrl0 && i_wdata[uclb_pkg::CTRL_TX_TRIG_BIT]),
        .i_length_code(cfg0[uclb_pkg::CTRL_LEN_HI:uclb_pkg::CTRL_LEN_LO]),
        .i_tx_invert(cfg0[uclb_pkg::CTRL_INV_BIT]),
        .o_tx_line(o_ch0_serial_tx_line),
        .o_rx_flag(rx_flag0),
        .o_rx_done(o_ch0_break_rx_irq),
        .o_tx_done(o_ch0_break_tx_irq)
    );

    uclb_chan u_chan1 (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_power_en(i_ch1_power_en),
        .i_tx_en(i_ch1_tx_en),
        .i_rx_en(i_ch1_rx_en),
        .i_baud_tick(i_ch1_baud_tick),
        .i_tx_normal(i_ch1_tx_normal),
        .i_rx_line(pin_sync[1]),
        .i_rx_start(wr_ctrl1 && i_wdata[uclb_pkg::CTRL_RX_TRIG_BIT]),
        .i_tx_start(wr_ctrl1 && i_wdata[uclb_pkg::CTRL_TX_TRIG_BIT]),
        .i_length_code(cfg1[uclb_pkg::CTRL_LEN_HI:uclb_pkg::CTRL_LEN_LO]),
        .i_tx_invert(cfg1[uclb_pkg::CTRL_INV_BIT]),
        .o_tx_line(o_ch1_serial_tx_line),
        .o_rx_flag(rx_flag1),
        .o_rx_done(o_ch1_break_rx_irq),
        .o_tx_done(o_ch1_break_tx_irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // Input routing, registered so every output leaves a flip-flop
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_external_irq_0 <= 1'b1;
            o_external_irq_1 <= 1'b1;
            o_timer_capture_in_a <= 1'b1;
            o_timer_capture_in_b <= 1'b1;
        end else begin
            o_external_irq_1 <= route[uclb_pkg::ROUTE_EXT1_BIT] ? rx1_eff : pin_sync[3];
            o_external_irq_0 <= route[uclb_pkg::ROUTE_EXT0_BIT] ? rx0_eff : pin_sync[2];
            o_timer_capture_in_b <= route[uclb_pkg::ROUTE_CAP_B_BIT] ? rx0_eff
                                                                     : pin_sync[5];
            o_timer_capture_in_a <= route[uclb_pkg::ROUTE_CAP_A_BIT] ? i_internal_timer_out
                                                                     : pin_sync[4];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_shared_irq <= 1'b0;
        end else begin
            o_shared_irq <= route[uclb_pkg::ROUTE_IRQ_SRC_BIT] ? i_muldiv_done_irq
                                                               : i_watch_interval_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_route_reset: assert property (@(posedge i_sys_clk)
        !i_resetn |=> (route == 8'h00 && o_shared_irq == 1'b0))
        else $error("route register not cleared by reset");
    a_ctrl_reset: assert property (@(posedge i_sys_clk)
        !i_resetn
        |=> (cfg1 == uclb_pkg::CTRL_RESET[uclb_pkg::CTRL_CFG_W-1:0] && !rx_flag1))
        else $error("control register reset value wrong");
    a_trig_read_zero: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (i_rd && (i_addr == uclb_pkg::ADDR_BREAK_CTRL_0
                  || i_addr == uclb_pkg::ADDR_BREAK_CTRL_1)) |=> o_rdata[6:5] == 2'h0)
        else $error("trigger bits read as one");
    a_flag_readback: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (i_rd && i_addr == uclb_pkg::ADDR_BREAK_CTRL_1) |=> o_rdata[7] == $past(rx_flag1))
        else $error("receive flag readback wrong");
    a_ext1_route: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        $past(i_resetn) |-> o_external_irq_1 == ($past(route[4]) ? $past(rx1_eff)
                                                                : $past(pin_sync[3])))
        else $error("external irq 1 routed wrong");
    a_shared_irq_src: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        (route[7] && i_muldiv_done_irq && !wr_route) |=> o_shared_irq)
        else $error("shared irq source select wrong");
    a_power_clears: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        !i_ch1_power_en |-> !rx_flag1)
        else $error("flag survives power off");
    a_power_clears0: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn)
        !i_ch0_power_en |-> !rx_flag0)
        else $error("channel 0 flag survives power off");
    a_ctrl_write: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn)
        wr_ctrl1 |=> cfg1 == $past(i_wdata[uclb_pkg::CTRL_CFG_W-1:0]))
        else $error("control register write lost");
    a_lsb_follows: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn)
        wr_ctrl1 |=> ##1 o_ch1_first_bit_lsb == $past(i_wdata[uclb_pkg::CTRL_DIR_BIT], 2))
        else $error("first bit select output wrong");
    // Routed outputs follow their selected source one cycle later
    a_ext0_route: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn)
        route[uclb_pkg::ROUTE_EXT0_BIT] |=> o_external_irq_0 == $past(rx0_eff))
        else $error("external irq 0 not fed from receive line");
    a_ext1_pin: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn)
        !route[uclb_pkg::ROUTE_EXT1_BIT] |=> o_external_irq_1 == $past(pin_sync[3]))
        else $error("external irq 1 not fed from its pin");
    a_cap_b_route: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn)
        route[uclb_pkg::ROUTE_CAP_B_BIT] |=> o_timer_capture_in_b == $past(rx0_eff))
        else $error("capture b not fed from receive line");
    a_cap_b_pin: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn)
        !route[uclb_pkg::ROUTE_CAP_B_BIT] |=> o_timer_capture_in_b == $past(pin_sync[5]))
        else $error("capture b not fed from its pin");
    a_cap_a_route: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn)
        route[uclb_pkg::ROUTE_CAP_A_BIT] |=> o_timer_capture_in_a == $past(i_internal_timer_out))
        else $error("capture a not fed from timer output");
    c_route_rx: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
        route[uclb_pkg::ROUTE_EXT0_BIT] && $fell(o_external_irq_0));
    c_tx_irq1: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
        o_ch1_break_tx_irq);
endmodule : uclb_top

// ===== bench/uclb_lin_node.sv
/* Remote LIN node model: drives the break field onto one receive line.
   Assumes bit ticks from the bench on the same clock; line idles high (pull-up). */
`timescale 1ns/100ps
module uclb_lin_node (
    input wire logic i_sys_clk,
    input wire logic i_baud_tick,
    output logic o_rx_line
);
    initial o_rx_line = 1'b1;
    // Dominant for a count of bit ticks; short counts model a bad break
    task automatic send_break(input int bits);
        int n;
        n = 0;
        @(negedge i_sys_clk);
        o_rx_line = 1'b0;
        while (n < bits) begin
            @(posedge i_sys_clk);
            if (i_baud_tick) n++;
        end
        @(negedge i_sys_clk);
        o_rx_line = 1'b1;
    endtask : send_break
endmodule : uclb_lin_node

// ===== bench/testbench.sv
/* Self-checking bench: registers, routing, break send and break receive.
   Assumes a 4 ns clock and a bit tick every fourth cycle on both channels. */
`timescale 1ns/100ps
module testbench;
    localparam logic [15:0] A0 = uclb_pkg::ADDR_BREAK_CTRL_0;
    localparam logic [15:0] A1 = uclb_pkg::ADDR_BREAK_CTRL_1;
    localparam logic [15:0] AR = uclb_pkg::ADDR_ROUTE_SEL;
    logic i_sys_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [15:0] i_addr = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] i_wdata = 8'h00;
    logic [7:0] o_rdata;
    logic [1:0] pwr = 2'h3;
    logic [1:0] txe = 2'h3;
    logic [1:0] rxe = 2'h3;
    logic tick = 1'b0;
    logic [1:0] ph = 2'h0;
    logic [6:0] pins = 7'h00;
    logic nrm = 1'b1;
    logic rx1 = 1'b1;
    logic rx0;
    logic [1:0] txl, lsb, rxirq, txirq;
    logic [4:0] rte;
    int failures = 0;
    int cmp_count = 0;
    always #2 i_sys_clk = ~i_sys_clk;
    always @(negedge i_sys_clk) begin
        ph <= ph + 2'h1;
        tick <= (ph == 2'h3);
    end
    uclb_lin_node u_uclb_lin_node (.i_sys_clk, .i_baud_tick(tick), .o_rx_line(rx0));
    uclb_top u_uclb_top (
        .i_sys_clk, .i_resetn, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata,
        .i_ch0_power_en(pwr[0]), .i_ch0_tx_en(txe[0]), .i_ch0_rx_en(rxe[0]),
        .i_ch0_baud_tick(tick), .i_ch0_tx_normal(nrm), .i_ch0_serial_rx_line(rx0),
        .o_ch0_serial_tx_line(txl[0]), .o_ch0_first_bit_lsb(lsb[0]),
        .o_ch0_break_rx_irq(rxirq[0]), .o_ch0_break_tx_irq(txirq[0]),
        .i_ch1_power_en(pwr[1]), .i_ch1_tx_en(txe[1]), .i_ch1_rx_en(rxe[1]),
        .i_ch1_baud_tick(tick), .i_ch1_tx_normal(nrm), .i_ch1_serial_rx_line(rx1),
        .o_ch1_serial_tx_line(txl[1]), .o_ch1_first_bit_lsb(lsb[1]),
        .o_ch1_break_rx_irq(rxirq[1]), .o_ch1_break_tx_irq(txirq[1]),
        .i_external_irq_0_pin(pins[0]), .i_external_irq_1_pin(pins[1]),
        .i_timer_capture_in_a_pin(pins[2]), .i_timer_capture_in_b_pin(pins[3]),
        .i_internal_timer_out(pins[4]), .i_watch_interval_irq(pins[5]),
        .i_muldiv_done_irq(pins[6]), .o_external_irq_0(rte[0]), .o_external_irq_1(rte[1]),
        .o_timer_capture_in_a(rte[2]), .o_timer_capture_in_b(rte[3]), .o_shared_irq(rte[4])
    );
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge i_sys_clk);
        i_addr = a;
        i_wdata = d;
        i_wr = 1'b1;
        @(negedge i_sys_clk);
        i_wr = 1'b0;
    endtask : wr
    // Read data lands one edge after the strobe and then holds
    task automatic rdc(input string what, input logic [15:0] a, input logic [7:0] e);
        @(negedge i_sys_clk);
        i_addr = a;
        i_rd = 1'b1;
        @(negedge i_sys_clk);
        i_rd = 1'b0;
        @(negedge i_sys_clk);
        chk(what, o_rdata, e);
    endtask : rdc
    task automatic end_sim;
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////
    task automatic t_reset;
        rdc("ctrl1 reset", A1, 8'h16);
        rdc("ctrl0 reset", A0, 8'h16);
        rdc("unmapped", 16'h0000, 8'h00);
        chk("lsb reset", {6'h0, lsb}, 8'h03);
        chk("idle outputs", {2'h0, txl, rxirq, txirq}, 8'h30);
        $display("done reset");
    endtask : t_reset
    task automatic t_route;
        rdc("route reset", AR, 8'h00);
        chk("pin path", {3'h0, rte}, 8'h00);
        pins = 7'h40;
        wr(AR, 8'hff);
        rdc("route rw", AR, 8'h9f);
        repeat (4) @(negedge i_sys_clk);
        chk("routed rx", {3'h0, rte}, 8'h1b);
        pins = 7'h50;
        rx1 = 1'b0;
        repeat (4) @(negedge i_sys_clk);
        chk("routed rx1", {3'h0, rte}, 8'h1d);
        rx1 = 1'b1;
        pins = 7'h2f;
        wr(AR, 8'h04);
        repeat (4) @(negedge i_sys_clk);
        chk("routed pins", {3'h0, rte}, 8'h1f);
        $display("done route");
    endtask : t_route
    task automatic t_tx(input logic [2:0] code, input int len);
        logic [7:0] cfg;
        int n;
        int k;
        cfg = {3'h0, code, 1'b0, code[0]};
        n = 0;
        @(negedge i_sys_clk);
        txe[1] = 1'b0;
        rxe[1] = 1'b0;
        wr(A1, cfg);
        @(negedge i_sys_clk);
        txe[1] = 1'b1;
        rxe[1] = 1'b1;
        wr(A1, cfg | 8'h20);
        for (k = 0; k < 400 && txirq[1] !== 1'b1; k++) begin
            @(negedge i_sys_clk);
            if (tick && txl[1] === code[0]) n++;
        end
        chk("tx irq", {7'h0, txirq[1]}, 8'h01);
        chk("tx length", n[7:0], len[7:0]);
        @(negedge i_sys_clk);
        chk("tx idle", {7'h0, txl[1]}, {7'h0, ~code[0]});
        nrm = 1'b0;
        repeat (2) @(negedge i_sys_clk);
        chk("tx normal", {7'h0, txl[1]}, {7'h0, code[0]});
        nrm = 1'b1;
        chk("msb first", {7'h0, lsb[1]}, 8'h00);
        rdc("tx ctrl", A1, cfg);
        $display("done tx %0d", len);
    endtask : t_tx
    task automatic t_rx;
        int k;
        wr(A0, 8'h56);
        rdc("rx flag on", A0, 8'h96);
        u_uclb_lin_node.send_break(5);
        repeat (6) @(negedge i_sys_clk);
        wr(A0, 8'h16);
        rdc("rx error", A0, 8'h96);
        u_uclb_lin_node.send_break(12);
        for (k = 0; k < 20 && rxirq[0] !== 1'b1; k++) @(negedge i_sys_clk);
        chk("rx irq", {7'h0, rxirq[0]}, 8'h01);
        rdc("rx done", A0, 8'h16);
        wr(A0, 8'h56);
        @(negedge i_sys_clk);
        pwr = 2'h0;
        rdc("power off", A0, 8'h16);
        pwr = 2'h3;
        $display("done rx");
    endtask : t_rx
    initial begin
        repeat (4) @(negedge i_sys_clk);
        i_resetn = 1'b1;
        t_reset();
        t_route();
        for (int c = 0; c < 8; c++) t_tx(c[2:0], c > 4 ? c + 8 : c + 16);
        t_rx();
        end_sim();
    end
endmodule : testbench
